// *** hw/ser_in_pkg.sv ***
// constants shared by the serial audio input stage
package ser_in_pkg;

  // framing selection
  typedef enum logic [1:0] {
    FMT_I2S = 2'h0,
    FMT_LJ  = 2'h1,
    FMT_RJ  = 2'h2
  } fmt_t;

  // word width selection
  typedef enum logic [1:0] {
    WW_16 = 2'h0,
    WW_18 = 2'h1,
    WW_20 = 2'h2,
    WW_24 = 2'h3
  } width_t;

  // bits per channel for each width
  localparam logic [4:0] BITS_16 = 5'h10;
  localparam logic [4:0] BITS_18 = 5'h12;
  localparam logic [4:0] BITS_20 = 5'h14;
  localparam logic [4:0] BITS_24 = 5'h18;

  // frame sync to msb delay in serial clocks
  localparam logic [5:0] I2S_DELAY = 6'h01;
  localparam logic [5:0] LJ_DELAY = 6'h00;
  localparam logic [5:0] RJ_DELAY_16 = 6'h10;
  localparam logic [5:0] RJ_DELAY_18 = 6'h0E;
  localparam logic [5:0] RJ_DELAY_20 = 6'h0C;
  localparam logic [5:0] RJ_DELAY_24 = 6'h08;

  // serial clocks per full frame sync period
  localparam int SCLK_PER_FRAME = 64;

  // data path
  localparam int SAMPLE_W = 24;
  localparam int WORD_W = SAMPLE_W + 1;
  localparam int FIFO_DEPTH = 8;

  // reset values
  localparam logic [5:0] CNT_RST = 6'h00;
  localparam logic [1:0] PTR_RST = 2'h0;

endpackage : ser_in_pkg

// *** hw/word_fifo.sv ***
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  // write side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // read side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // handshake terms
  assign push = en_i && in_valid_i && (cnt_q != (AW+1)'(DEPTH));
  assign pop = en_i && out_ready_i && (cnt_q != '0);
  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];

  // pointer and count next values
  always_comb begin
    wr_d = push ? AW'(wr_q + 1'b1) : wr_q;
    rd_d = pop ? AW'(rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // pointer registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage, one entry per slot
  for (genvar g = 0; g < DEPTH; g++) begin : g_mem
    always_ff @(posedge clk_i) begin
      if (push && wr_q == AW'(g)) begin
        mem_q[g] <= in_data_i;
      end
    end
  end

endmodule // word_fifo

`default_nettype wire

// *** hw/ser_audio_in.sv ***
// serial audio input stage: link capture, crossing, buffering
`timescale 1ns/1ps
`default_nettype none

module ser_audio_in
  import ser_in_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // core clock domain
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  // configuration, static while running
  input wire logic [1:0] fmt_i,
  input wire logic [1:0] width_i,
  // serial link
  input wire logic sclk_i,
  input wire logic fs_i,
  input wire logic sdata_i,
  // sample output stream
  output logic smp_valid_o,
  input wire logic smp_ready_i,
  output logic [SAMPLE_W-1:0] smp_data_o,
  output logic smp_right_o,
  // status
  output logic overrun_o
);

  // ---------------------------------------------------------------
  // link-domain reset and configuration crossing
  // ---------------------------------------------------------------
  logic lrst_m_q, lrst_q;
  logic [3:0] cfg_m_q, cfg_q;

  // reset released synchronously to sclk
  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      lrst_m_q <= 1'b1;
      lrst_q <= 1'b1;
    end else begin
      lrst_m_q <= 1'b0;
      lrst_q <= lrst_m_q;
    end
  end

  // configuration passes two flops on sclk
  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_m_q <= 4'h0;
      cfg_q <= 4'h0;
    end else begin
      cfg_m_q <= {fmt_i, width_i};
      cfg_q <= cfg_m_q;
    end
  end

  fmt_t fmt;
  width_t wsel;
  assign fmt = fmt_t'(cfg_q[3:2]);
  assign wsel = width_t'(cfg_q[1:0]);

  // ---------------------------------------------------------------
  // link-domain capture
  // ---------------------------------------------------------------
  logic fs_q, fs_d;
  logic [5:0] cnt_q, cnt_d;
  logic [SAMPLE_W-1:0] sh_q, sh_d;
  logic [SAMPLE_W-1:0] word_q, word_d;
  logic right_q, right_d;
  logic tog_q, tog_d;
  logic [5:0] delay;
  logic [4:0] nbits;
  logic edge_fs, left_now;

  // bits per channel and msb delay per framing
  always_comb begin
    case (wsel)
      WW_16: nbits = BITS_16;
      WW_18: nbits = BITS_18;
      WW_20: nbits = BITS_20;
      WW_24: nbits = BITS_24;
      default: nbits = BITS_24;
    endcase
    case (fmt)
      FMT_I2S: delay = I2S_DELAY;
      FMT_LJ: delay = LJ_DELAY;
      FMT_RJ: begin
        // delays line lsb up with next sync edge at 64 clocks/frame
        case (wsel)
          WW_16: delay = RJ_DELAY_16;
          WW_18: delay = RJ_DELAY_18;
          WW_20: delay = RJ_DELAY_20;
          default: delay = RJ_DELAY_24;
        endcase
      end
      default: delay = I2S_DELAY;
    endcase
  end

  // channel decode: lj and rj high is left, i2s and code 3 low is left
  assign edge_fs = (fs_i != fs_q);
  assign left_now = (fmt == FMT_LJ || fmt == FMT_RJ) ? fs_i : !fs_i;

  // bit counter within a half frame and shift register
  always_comb begin
    fs_d = fs_i;
    cnt_d = cnt_q;
    sh_d = sh_q;
    word_d = word_q;
    right_d = right_q;
    tog_d = tog_q;
    if (edge_fs) begin
      cnt_d = 6'h01;
    end else if (cnt_q != 6'h3F) begin
      cnt_d = cnt_q + 6'h01;
    end
    // slot index of this rising edge after the sync transition
    if ((edge_fs ? 6'h00 : cnt_q) >= delay &&
        (edge_fs ? 6'h00 : cnt_q) < delay + {1'b0, nbits}) begin
      sh_d = {sh_q[SAMPLE_W-2:0], sdata_i};
      if ((edge_fs ? 6'h00 : cnt_q) == delay + {1'b0, nbits} - 6'h01) begin
        // msb-align the captured word in the sample field
        word_d = {sh_q[SAMPLE_W-2:0], sdata_i} << (5'h18 - nbits);
        right_d = !left_now;
        tog_d = !tog_q;
      end
    end
  end

  // link capture registers, sampled on the rising serial clock edge
  always_ff @(posedge sclk_i or posedge lrst_q) begin
    if (lrst_q) begin
      fs_q <= 1'b0;
      cnt_q <= 6'h3F;
      sh_q <= '0;
      word_q <= '0;
      right_q <= 1'b0;
      tog_q <= 1'b0;
    end else begin
      fs_q <= fs_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      word_q <= word_d;
      right_q <= right_d;
      tog_q <= tog_d;
    end
  end

  // ---------------------------------------------------------------
  // core-domain crossing: toggle event, word held stable meanwhile
  // ---------------------------------------------------------------
  logic tog_m_q, tog_s_q, tog_p_q;
  logic tog_s_d, tog_p_d;
  logic push;
  logic fifo_ready;
  logic ovr_q, ovr_d;

  // first flop of the two-flop synchroniser, on its own
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tog_m_q <= 1'b0;
    end else if (clk_en_i) begin
      tog_m_q <= tog_q;
    end
  end

  // edge detect after the second flop, overrun flag sticky
  always_comb begin
    tog_s_d = tog_m_q;
    tog_p_d = tog_s_q;
    ovr_d = ovr_q || (push && !fifo_ready);
  end

  assign push = clk_en_i && (tog_s_q != tog_p_q);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tog_s_q <= 1'b0;
      tog_p_q <= 1'b0;
      ovr_q <= 1'b0;
    end else if (clk_en_i) begin
      tog_s_q <= tog_s_d;
      tog_p_q <= tog_p_d;
      ovr_q <= ovr_d;
    end
  end

  // ---------------------------------------------------------------
  // buffering and registered outputs
  // ---------------------------------------------------------------
  logic f_valid;
  logic f_pop;
  logic [WORD_W-1:0] f_data;
  logic out_v_q, out_v_d;
  logic [WORD_W-1:0] out_q, out_d;

  word_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_i(core_clk_i),
    .rst_i(rst_i),
    .en_i(clk_en_i),
    .in_valid_i(push),
    .in_ready_o(fifo_ready),
    .in_data_i({right_q, word_q}),
    .out_valid_o(f_valid),
    .out_ready_i(f_pop),
    .out_data_o(f_data)
  );

  // output register refills when empty or being taken
  assign f_pop = clk_en_i && (!out_v_q || smp_ready_i);

  always_comb begin
    out_v_d = out_v_q;
    out_d = out_q;
    if (!out_v_q || smp_ready_i) begin
      out_v_d = f_valid;
      if (f_valid) begin
        out_d = f_data;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_v_q <= 1'b0;
      out_q <= '0;
    end else if (clk_en_i) begin
      out_v_q <= out_v_d;
      out_q <= out_d;
    end
  end

  assign smp_valid_o = out_v_q;
  assign smp_data_o = out_q[SAMPLE_W-1:0];
  assign smp_right_o = out_q[SAMPLE_W];
  assign overrun_o = ovr_q;

endmodule // ser_audio_in

`default_nettype wire

// *** sim/ser_src_model.sv ***
// upstream serial audio source model
`timescale 1ns/1ps
`default_nettype none
module ser_src_model
  import ser_in_pkg::*;
(
  // configuration
  input wire logic [1:0] fmt_i,
  input wire logic [1:0] width_i,
  // serial link
  output logic sclk_o,
  output logic fs_o,
  output logic sdata_o
);
  int nb, dl;
  initial begin
    sclk_o = 1'b0;
    fs_o = 1'b1;
    sdata_o = 1'b0;
  end
  // fs level of the left half; fmt 3 runs as i2s
  function automatic logic lft();
    return fmt_i == FMT_LJ || fmt_i == FMT_RJ;
  endfunction
  // ----
  // link clock keeps running for n cycles between frames, fs at the right-half level
  // ----
  task automatic idle(input int n);
    repeat (n) begin
      sclk_o = 1'b0;
      fs_o = ~lft();
      sdata_o = ~sdata_o;
      #40 sclk_o = 1'b1;
      #40;
    end
    sclk_o = 1'b0;
  endtask
  // 32 slots; bits change on the falling edge, valid at rising
  task automatic half(input logic lvl, input logic [23:0] s);
    for (int n = 0; n < 32; n++) begin
      sclk_o = 1'b0;
      fs_o = lvl;
      sdata_o = (n >= dl && n < dl + nb) ? s[23-(n-dl)] : 1'($urandom);
      #40 sclk_o = 1'b1;
      #40;
    end
  endtask
  // one full 64-clock frame, left then right
  task automatic send(input logic [23:0] l, input logic [23:0] r);
    nb = 16 + 2 * int'(width_i) + (width_i == 2'h3 ? 2 : 0);
    dl = fmt_i == FMT_LJ ? 0 : fmt_i == FMT_RJ ? 32 - nb : 1;
    half(lft(), l);
    half(~lft(), r);
    sclk_o = 1'b0;
    sdata_o = ~sdata_o;
  endtask
endmodule // ser_src_model
`default_nettype wire

// *** sim/ser_audio_in_props.sv ***
// checker for the serial audio input stage
`timescale 1ns/1ps
`default_nettype none
module ser_audio_in_props
  import ser_in_pkg::*;
#(parameter int DEPTH = FIFO_DEPTH) (
  // core side
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic [1:0] width_i,
  // sample stream
  input wire logic smp_valid_o,
  input wire logic smp_ready_i,
  input wire logic [SAMPLE_W-1:0] smp_data_o,
  input wire logic smp_right_o,
  input wire logic overrun_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // channel of the last word taken
  logic seen_q, seen_d, last_q, last_d;
  always_comb begin
    seen_d = seen_q | (smp_valid_o & smp_ready_i & clk_en_i);
    last_d = (smp_valid_o & smp_ready_i & clk_en_i) ? smp_right_o : last_q;
  end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) {seen_q, last_q} <= 2'h0;
    else {seen_q, last_q} <= {seen_d, last_d};
  end
  // ----
  // properties
  // ----
  sequence s_wait; smp_valid_o && !(smp_ready_i && clk_en_i); endsequence
  property p_hold_v; s_wait |=> smp_valid_o; endproperty
  a_hold_v: assert property (p_hold_v) else $error("valid dropped");
  property p_hold_d; s_wait |=> $stable({smp_right_o, smp_data_o}); endproperty
  a_hold_d: assert property (p_hold_d) else $error("word moved");
  property p_freeze; !clk_en_i |=> $stable({smp_valid_o, smp_data_o}); endproperty
  a_freeze: assert property (p_freeze) else $error("moved while frozen");
  property p_w16; smp_valid_o && width_i == WW_16 |-> !(|smp_data_o[7:0]); endproperty
  a_w16: assert property (p_w16) else $error("extra bits at 16");
  property p_w18; smp_valid_o && width_i == WW_18 |-> !(|smp_data_o[5:0]); endproperty
  a_w18: assert property (p_w18) else $error("extra bits at 18");
  property p_w20; smp_valid_o && width_i == WW_20 |-> !(|smp_data_o[3:0]); endproperty
  a_w20: assert property (p_w20) else $error("extra bits at 20");
  property p_alt; smp_valid_o && seen_q && !overrun_o |-> smp_right_o != last_q; endproperty
  a_alt: assert property (p_alt) else $error("channels out of turn");
  property p_ovr; overrun_o |=> overrun_o; endproperty
  a_ovr: assert property (p_ovr) else $error("overrun flag cleared");
endmodule // ser_audio_in_props
bind ser_audio_in ser_audio_in_props #(.DEPTH(DEPTH)) ser_audio_in_props_inst (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .width_i(width_i),
  .smp_valid_o(smp_valid_o), .smp_ready_i(smp_ready_i), .smp_data_o(smp_data_o),
  .smp_right_o(smp_right_o), .overrun_o(overrun_o));
`default_nettype wire

// *** sim/testbench.sv ***
// self-checking bench for the serial audio input stage
`timescale 1ns/1ps
`default_nettype none
module testbench
  import ser_in_pkg::*;
;
  logic core_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, ready = 1'b0, hold = 1'b0;
  logic [1:0] fmt = 2'h0, width = 2'h0;
  logic sclk, fs, sdata, valid, right, ovr;
  logic [SAMPLE_W-1:0] data;
  int failures = 0, n_checks = 0;
  logic [SAMPLE_W:0] exp_q[$];
  always #2.5 core_clk = ~core_clk;
  ser_audio_in ser_audio_in_inst (.core_clk_i(core_clk), .rst_i(rst),
    .clk_en_i(clk_en), .fmt_i(fmt), .width_i(width), .sclk_i(sclk), .fs_i(fs),
    .sdata_i(sdata), .smp_valid_o(valid), .smp_ready_i(ready),
    .smp_data_o(data), .smp_right_o(right), .overrun_o(ovr));
  ser_src_model ser_src_model_inst (.fmt_i(fmt), .width_i(width),
    .sclk_o(sclk), .fs_o(fs), .sdata_o(sdata));
  // ----
  // checking
  // ----
  task automatic check(input logic [SAMPLE_W:0] got, input logic [SAMPLE_W:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // captured bits, msb-aligned
  function automatic logic [23:0] mask(input logic [1:0] w);
    logic [4:0] b;
    b = w == WW_16 ? BITS_16 : w == WW_18 ? BITS_18 : w == WW_20 ? BITS_20 : BITS_24;
    return ~24'h0 << (5'd24 - b);
  endfunction
  // consumer: compare each word handed over
  always @(posedge core_clk) begin
    if (!rst && !hold && valid === 1'b1 && ready && clk_en)
      check({right, data}, exp_q.size() != 0 ? exp_q.pop_front() : 'x);
    #1;
    ready <= hold ? 1'b0 : ($urandom % 4 != 0);
    clk_en <= ($urandom % 8 != 0);
  end
  task automatic restart();
    rst = 1'b1;
    ser_src_model_inst.idle(4);
    @(posedge core_clk) #1 rst = 1'b0;
    ser_src_model_inst.idle(3);
  endtask
  task automatic run(input int frames);
    logic [23:0] l, r;
    for (int f = 0; f < frames; f++) begin
      l = f == 0 ? 24'hFFFFFF : 24'($urandom);
      r = f == 0 ? 24'h000000 : 24'($urandom);
      exp_q.push_back({1'b0, l & mask(width)});
      exp_q.push_back({1'b1, r & mask(width)});
      ser_src_model_inst.send(l, r);
    end
    repeat (400) if (exp_q.size() != 0) @(posedge core_clk);
  endtask
  task automatic finish_test();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #500us;
    failures++;
    finish_test();
  end
  // ----
  // every framing at every width, then a stalled consumer
  // ----
  initial begin
    void'($urandom(32'h5fc82d73));
    for (int f = 0; f < 4; f++) begin
      for (int w = 0; w < 4; w++) begin
        fmt = 2'(f);
        width = 2'(w);
        restart();
        run(3);
        check(25'(exp_q.size()), 25'h0);
        check({24'h0, ovr}, 25'h0);
        $display("test fmt=%0d width=%0d done", f, w);
      end
    end
    hold = 1'b1;
    run(6);
    check({24'h0, ovr}, 25'h1);
    $display("test overrun done");
    finish_test();
  end
endmodule // testbench
`default_nettype wire
